// [branch_and_increment_exec.sv]
// Executes direct increment, the conditional relative jumps and the
// indexed indirect jump for the core. Assumes the core's data memory and
// bit space answer a read within the read strobe's own clk cycle.
//
// Behaviour
// - Direct increment reads the addressed byte, adds one, writes it back.
// - Jump on bit set: pc plus three, branch only when bit is one.
// - Jump and clear: pc plus three; if bit set, clear it and branch.
// - Jump on carry: pc plus two, branch only when carry is one.
// - Jump on bit clear: pc plus three, branch only when bit is zero.
// - Indexed jump loads pc with accumulator plus data pointer, sources kept.
// - Taken relative branch target is incremented pc plus the offset byte.
// - Failed test continues at incremented pc, the next instruction.
`timescale 1ns/1ps
`include "exec_cfg.svh"

module branch_and_increment_exec (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  operand_a,
  input  wire logic [7:0]  operand_b,
  input  wire logic [15:0] pc_in,
  input  wire logic [7:0]  accumulator,
  input  wire logic [15:0] data_pointer_16,
  input  wire logic        carry_flag,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        bit_rdata,
  output logic             busy,
  output logic             done,
  output logic             illegal,
  output logic             branch_taken,
  output logic [15:0]      pc_out,
  output logic [7:0]       mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [7:0]       mem_wdata,
  output logic [7:0]       bit_addr,
  output logic             bit_rd,
  output logic             bit_wr,
  output logic             bit_wdata
);

  // Sign extend the offset and add; the 16-bit result wraps by design
  function automatic exec_pkg::addr_t rel_add(
    input exec_pkg::addr_t base,
    input logic [7:0]      off
  );
    exec_pkg::addr_t ext;
    ext = {{8{off[7]}}, off};
    rel_add = base + ext;
  endfunction : rel_add

  exec_pkg::exec_state_e state_q, state_d;
  logic [7:0]      opc_q, opc_d;
  logic [7:0]      rel_q, rel_d;
  exec_pkg::addr_t next_pc_q, next_pc_d;
  logic            busy_q, busy_d;
  logic            done_q, done_d;
  logic            illegal_q, illegal_d;
  logic            taken_q, taken_d;
  logic [15:0]     pc_q, pc_d;
  logic [7:0]      mem_addr_q, mem_addr_d;
  logic            mem_rd_q, mem_rd_d;
  logic            mem_wr_q, mem_wr_d;
  logic [7:0]      mem_wdata_q, mem_wdata_d;
  logic [7:0]      bit_addr_q, bit_addr_d;
  logic            bit_rd_q, bit_rd_d;
  logic            bit_wr_q, bit_wr_d;
  logic            bit_wdata_q, bit_wdata_d;

  // Decode on start; memory-backed opcodes wait one clock for read data
  always_comb begin
    state_d     = state_q;
    opc_d       = opc_q;
    rel_d       = rel_q;
    next_pc_d   = next_pc_q;
    busy_d      = busy_q;
    done_d      = 1'b0;
    illegal_d   = 1'b0;
    taken_d     = taken_q;
    pc_d        = pc_q;
    mem_addr_d  = mem_addr_q;
    mem_rd_d    = 1'b0;
    mem_wr_d    = 1'b0;
    mem_wdata_d = mem_wdata_q;
    bit_addr_d  = bit_addr_q;
    bit_rd_d    = 1'b0;
    bit_wr_d    = 1'b0;
    bit_wdata_d = bit_wdata_q;
    case (state_q)
      exec_pkg::ST_IDLE: begin
        if (start) begin
          opc_d = opcode;
          case (opcode)
            `OPC_INC_DIRECT: begin
              mem_addr_d = operand_a;
              mem_rd_d   = 1'b1;
              next_pc_d  = pc_in + `LEN_TWO;
              busy_d     = 1'b1;
              state_d    = exec_pkg::ST_WAIT;
            end
            `OPC_JUMP_BIT_SET,
            `OPC_JUMP_BIT_CLR,
            `OPC_JUMP_BIT_NSET: begin
              bit_addr_d = operand_a;
              bit_rd_d   = 1'b1;
              rel_d      = operand_b;
              next_pc_d  = pc_in + `LEN_THREE;
              busy_d     = 1'b1;
              state_d    = exec_pkg::ST_WAIT;
            end
            `OPC_JUMP_CARRY: begin
              // Carry is already at hand, so answer without a read
              done_d  = 1'b1;
              taken_d = carry_flag;
              if (carry_flag) begin
                pc_d = rel_add(pc_in + `LEN_TWO, operand_a);
              end else begin
                pc_d = pc_in + `LEN_TWO;
              end
            end
            `OPC_JUMP_INDEXED: begin
              // Sources are only read, never written back
              done_d  = 1'b1;
              taken_d = 1'b1;
              pc_d    = data_pointer_16 + {8'h00, accumulator};
            end
            default: begin
              // Not ours: pc advances by one so the core is not stuck
              done_d    = 1'b1;
              illegal_d = 1'b1;
              taken_d   = 1'b0;
              pc_d      = pc_in + `LEN_ONE;
            end
          endcase
        end
      end
      exec_pkg::ST_WAIT: begin
        state_d = exec_pkg::ST_IDLE;
        busy_d  = 1'b0;
        done_d  = 1'b1;
        case (opc_q)
          `OPC_INC_DIRECT: begin
            mem_wr_d    = 1'b1;
            mem_wdata_d = mem_rdata + `BYTE_ONE;
            taken_d     = 1'b0;
            pc_d        = next_pc_q;
          end
          `OPC_JUMP_BIT_SET: begin
            taken_d = bit_rdata;
            pc_d    = bit_rdata ? rel_add(next_pc_q, rel_q)
                                : next_pc_q;
          end
          `OPC_JUMP_BIT_CLR: begin
            taken_d = bit_rdata;
            if (bit_rdata) begin
              bit_wr_d    = 1'b1;
              bit_wdata_d = `BIT_CLEARED;
              pc_d        = rel_add(next_pc_q, rel_q);
            end else begin
              pc_d = next_pc_q;
            end
          end
          `OPC_JUMP_BIT_NSET: begin
            taken_d = ~bit_rdata;
            pc_d    = bit_rdata ? next_pc_q
                                : rel_add(next_pc_q, rel_q);
          end
          default: begin
            pc_d = next_pc_q;
          end
        endcase
      end
      default: begin
        state_d = exec_pkg::ST_IDLE;
        busy_d  = 1'b0;
      end
    endcase
  end

  // Registers only; synchronous reset to idle with strobes low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q     <= exec_pkg::ST_IDLE;
      opc_q       <= 8'h00;
      rel_q       <= 8'h00;
      next_pc_q   <= 16'h0000;
      busy_q      <= 1'b0;
      done_q      <= 1'b0;
      illegal_q   <= 1'b0;
      taken_q     <= 1'b0;
      pc_q        <= 16'h0000;
      mem_addr_q  <= 8'h00;
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
      mem_wdata_q <= 8'h00;
      bit_addr_q  <= 8'h00;
      bit_rd_q    <= 1'b0;
      bit_wr_q    <= 1'b0;
      bit_wdata_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      opc_q       <= opc_d;
      rel_q       <= rel_d;
      next_pc_q   <= next_pc_d;
      busy_q      <= busy_d;
      done_q      <= done_d;
      illegal_q   <= illegal_d;
      taken_q     <= taken_d;
      pc_q        <= pc_d;
      mem_addr_q  <= mem_addr_d;
      mem_rd_q    <= mem_rd_d;
      mem_wr_q    <= mem_wr_d;
      mem_wdata_q <= mem_wdata_d;
      bit_addr_q  <= bit_addr_d;
      bit_rd_q    <= bit_rd_d;
      bit_wr_q    <= bit_wr_d;
      bit_wdata_q <= bit_wdata_d;
    end
  end

  // Every output straight from a flop
  assign busy         = busy_q;
  assign done         = done_q;
  assign illegal      = illegal_q;
  assign branch_taken = taken_q;
  assign pc_out       = pc_q;
  assign mem_addr     = mem_addr_q;
  assign mem_rd       = mem_rd_q;
  assign mem_wr       = mem_wr_q;
  assign mem_wdata    = mem_wdata_q;
  assign bit_addr     = bit_addr_q;
  assign bit_rd       = bit_rd_q;
  assign bit_wr       = bit_wr_q;
  assign bit_wdata    = bit_wdata_q;

endmodule : branch_and_increment_exec

// [branch_and_increment_exec_bench.sv]
// Random instruction bench for the branch and increment executor.
// Assumes the model and checker files are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
  $display("ERROR %0t: %h vs %h", $time, a, e); end end
module branch_and_increment_exec_bench;
  logic clk = 0, rst_n = 0, start = 0, carry_flag = 0, tk;
  logic [7:0] opcode = '0, operand_a = '0, operand_b = '0;
  logic [7:0] accumulator = '0, mem_rdata, mem_addr, mem_wdata, bit_addr;
  logic [15:0] pc_in = '0, data_pointer_16 = '0, pc_out, npc, rel;
  logic bit_rdata, busy, done, illegal, branch_taken, mem_rd, mem_wr;
  logic bit_rd, bit_wr, bit_wdata, shb [256];
  logic [7:0] sh [256];
  logic [17:0] q [$], note;
  logic [7:0] ops [7] = '{8'h05, 8'h20, 8'h10, 8'h30, 8'h40, 8'h73, 8'h00};
  int errors = 0, checks = 0;
  branch_and_increment_exec uut (
    .clk             (clk),
    .rst_n           (rst_n),
    .start           (start),
    .opcode          (opcode),
    .operand_a       (operand_a),
    .operand_b       (operand_b),
    .pc_in           (pc_in),
    .accumulator     (accumulator),
    .data_pointer_16 (data_pointer_16),
    .carry_flag      (carry_flag),
    .mem_rdata       (mem_rdata),
    .bit_rdata       (bit_rdata),
    .busy            (busy),
    .done            (done),
    .illegal         (illegal),
    .branch_taken    (branch_taken),
    .pc_out          (pc_out),
    .mem_addr        (mem_addr),
    .mem_rd          (mem_rd),
    .mem_wr          (mem_wr),
    .mem_wdata       (mem_wdata),
    .bit_addr        (bit_addr),
    .bit_rd          (bit_rd),
    .bit_wr          (bit_wr),
    .bit_wdata       (bit_wdata)
  );
  data_space_model pm (
    .clk       (clk),
    .mem_addr  (mem_addr),
    .mem_rd    (mem_rd),
    .mem_wr    (mem_wr),
    .mem_wdata (mem_wdata),
    .bit_addr  (bit_addr),
    .bit_rd    (bit_rd),
    .bit_wr    (bit_wr),
    .bit_wdata (bit_wdata),
    .mem_rdata (mem_rdata),
    .bit_rdata (bit_rdata)
  );
  // Half period of 2 ns gives the 250 MHz core clock
  always #2 clk = ~clk;
  // Oldest note pairs with each done pulse
  always @(negedge clk) begin
    if (done === 1'b1) begin
      `CHK(q.size() > 0, 1'b1)
      // Popped once here; the macro reads its arguments twice on a miss
      note = q.pop_front();
      `CHK({illegal, branch_taken, pc_out}, note)
    end
  end
  // Start stays high through wait cycles, so refusal is exercised too
  task automatic issue(input logic [7:0] op);
    {operand_a, operand_b, accumulator} = 24'($urandom);
    {pc_in, data_pointer_16} = $urandom;
    carry_flag = 1'($urandom);
    opcode = op;
    start = 1;
    rel = {{8{operand_b[7]}}, operand_b};
    if (op == 8'h40) rel = {{8{operand_a[7]}}, operand_a};
    tk = op == 8'h40 ? carry_flag : shb[operand_a] ^ (op == 8'h30);
    npc = pc_in + (op inside {8'h05, 8'h40} ? 16'h0002 : 16'h0003);
    if (op == 8'h00) npc = pc_in + 16'h0001;
    if (op inside {8'h20, 8'h10, 8'h30, 8'h40} && tk) npc = npc + rel;
    else tk = 0;
    if (op == 8'h05) sh[operand_a] = sh[operand_a] + 8'h01;
    if (op == 8'h10) shb[operand_a] = 1'b0;
    if (op == 8'h73) begin
      tk = 1;
      npc = data_pointer_16 + {8'h00, accumulator};
    end
    q.push_back({op == 8'h00, tk, npc});
    @(negedge clk);
    if (op inside {8'h05, 8'h20, 8'h10, 8'h30}) @(negedge clk);
  endtask : issue
  task automatic summarize();
    if (errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  // Main sequence: reset, random instructions, final memory audit
  initial begin
    void'($urandom(32'h7671));
    for (int i = 0; i < 256; i++) begin
      {sh[i], shb[i]} = 9'($urandom);
      pm.mem[i] = sh[i];
      pm.bits[i] = shb[i];
    end
    repeat (6) @(negedge clk);
    rst_n = 1;
    repeat (400) issue(ops[$urandom_range(6)]);
    start = 0;
    repeat (3) @(negedge clk);
    `CHK(q.size(), 0)
    for (int i = 0; i < 256; i++) begin
      `CHK(pm.mem[i], sh[i])
      `CHK(pm.bits[i], shb[i])
    end
    summarize();
  end
  // Watchdog well beyond the roughly 640 cycles of traffic
  initial begin
    #20000;
    errors++;
    summarize();
  end
endmodule : branch_and_increment_exec_bench
bind branch_and_increment_exec exec_checker chk (
  .clk             (clk),
  .rst_n           (rst_n),
  .start           (start),
  .busy            (busy),
  .done            (done),
  .branch_taken    (branch_taken),
  .carry_flag      (carry_flag),
  .mem_rd          (mem_rd),
  .mem_wr          (mem_wr),
  .bit_rd          (bit_rd),
  .bit_wr          (bit_wr),
  .bit_wdata       (bit_wdata),
  .opcode          (opcode),
  .operand_a       (operand_a),
  .mem_rdata       (mem_rdata),
  .mem_wdata       (mem_wdata),
  .pc_in           (pc_in),
  .pc_out          (pc_out),
  .accumulator     (accumulator),
  .data_pointer_16 (data_pointer_16)
);

// [data_space_model.sv]
// Data bytes and bit space behind the executor's strobes.
// Assumes reads are answered within the strobe's own cycle.
`timescale 1ns/1ps
module data_space_model (
  input wire logic clk,
  input wire logic [7:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] bit_addr,
  input wire logic bit_rd,
  input wire logic bit_wr,
  input wire logic bit_wdata,
  output logic [7:0] mem_rdata,
  output logic bit_rdata
);
  logic [7:0] mem [256];
  logic bits [256];
  // Inverted off strobe so a mistimed sample never matches
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
  assign bit_rdata = bit_rd ? bits[bit_addr] : ~bits[bit_addr];
  // Write-backs land at the edge that ends the done pulse
  always @(posedge clk) begin
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    if (bit_wr) bits[bit_addr] <= bit_wdata;
  end
endmodule : data_space_model

// [exec_cfg.svh]
// Opcodes, instruction lengths and write-back constants of the branch and
// increment executor. Assumes inclusion by bare name from the design.
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

`define OPC_INC_DIRECT     8'h05
`define OPC_JUMP_BIT_SET   8'h20
`define OPC_JUMP_BIT_CLR   8'h10
`define OPC_JUMP_CARRY     8'h40
`define OPC_JUMP_BIT_NSET  8'h30
`define OPC_JUMP_INDEXED   8'h73

`define LEN_TWO            16'h0002
`define LEN_THREE          16'h0003
`define LEN_ONE            16'h0001

`define BYTE_ONE           8'h01
`define BIT_CLEARED        1'b0

`endif

// [exec_checker.sv]
// Port checker for the branch and increment executor.
// Bound by the bench; sees executor ports only.
`timescale 1ns/1ps
module exec_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic busy,
  input wire logic done,
  input wire logic branch_taken,
  input wire logic carry_flag,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic bit_rd,
  input wire logic bit_wr,
  input wire logic bit_wdata,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand_a,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] mem_wdata,
  input wire logic [15:0] pc_in,
  input wire logic [15:0] pc_out,
  input wire logic [7:0] accumulator,
  input wire logic [15:0] data_pointer_16
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Taken only when idle; start held during the wait cycle is ignored
  wire logic go = start && !busy;
  wire logic [15:0] rel = {{8{operand_a[7]}}, operand_a};
  // Accumulator widened so the indexed sum is checked at full width
  wire logic [15:0] acc_ext = {8'h00, accumulator};
  chk_inc_seq: assert property (go && opcode == 8'h05 |=>
    mem_rd && busy ##1 done && !busy) else $error("bad inc timing");
  chk_inc_sum: assert property (mem_wr |-> done &&
    mem_wdata == $past(mem_rdata) + 8'h01) else $error("bad inc value");
  chk_set_seq: assert property (go && opcode == 8'h20 |=>
    bit_rd ##1 done) else $error("bad bit test timing");
  chk_nset_seq: assert property (go && opcode == 8'h30 |=>
    bit_rd ##1 done && !bit_wr) else $error("bad bit clear test");
  chk_bit_clear: assert property (bit_wr |->
    done && !bit_wdata && branch_taken) else $error("bad bit clear");
  chk_carry_flag: assert property (go && opcode == 8'h40 |=>
    done && branch_taken == $past(carry_flag)) else $error("bad carry");
  chk_carry_pc: assert property (go && opcode == 8'h40 &&
    carry_flag |=> pc_out == $past(pc_in) + 16'h0002 + $past(rel))
    else $error("bad carry target");
  chk_fall_thru: assert property (go && opcode == 8'h40 &&
    !carry_flag |=> pc_out == $past(pc_in) + 16'h0002)
    else $error("bad fall through");
  chk_index_jump: assert property (go && opcode == 8'h73 |=>
    done && branch_taken &&
    pc_out == $past(data_pointer_16) + $past(acc_ext))
    else $error("bad indexed jump");
endmodule : exec_checker

// [exec_pkg.sv]
// Types shared by the branch and increment executor.
// Assumes exec_cfg.svh supplies the numeric constants.
package exec_pkg;

  // Gray coded along idle -> wait -> idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01
  } exec_state_e;

  typedef logic [15:0] addr_t;

endpackage : exec_pkg
